/* File: inc/sarc_pkg.sv */
package sarc_pkg;

    // ------------------------------------------------------------
    // Register addresses
    // ------------------------------------------------------------
    localparam logic [7:0] SARC_ADDR_CONFIG  = 8'hbc;
    localparam logic [7:0] SARC_ADDR_RES_LOW = 8'hbd;
    localparam logic [7:0] SARC_ADDR_RES_HI  = 8'hbe;

    // ------------------------------------------------------------
    // Reset values
    // ------------------------------------------------------------
    localparam logic [7:0] SARC_CONFIG_RST = 8'hf9;
    localparam logic [7:0] SARC_BYTE_ZERO  = 8'h00;

    // ------------------------------------------------------------
    // Field positions of the configuration register
    // ------------------------------------------------------------
    localparam int SARC_DIV_MSB   = 7;
    localparam int SARC_DIV_LSB   = 3;
    localparam int SARC_LJST_BIT  = 2;
    localparam int SARC_8BIT_BIT  = 1;
    localparam int SARC_GAIN_BIT  = 0;
    localparam int SARC_DIV_W     = 5;

    // ------------------------------------------------------------
    // Conversion timing in conversion clock cycles
    // ------------------------------------------------------------
    localparam logic [3:0] SARC_BITS_10    = 4'ha;
    localparam logic [3:0] SARC_BITS_8     = 4'h8;
    localparam logic [3:0] SARC_TRACK_DLY  = 4'h3;
    localparam logic [3:0] SARC_CNT_ZERO   = 4'h0;
    localparam logic [3:0] SARC_CNT_ONE    = 4'h1;
    localparam logic [4:0] SARC_DIV_ZERO   = 5'h00;
    localparam logic [4:0] SARC_DIV_ONE    = 5'h01;

    // ------------------------------------------------------------
    // Sequencer states
    // ------------------------------------------------------------
    typedef enum logic [1:0]
    {
        SARC_IDLE  = 2'b00,
        SARC_DELAY = 2'b01,
        SARC_CONV  = 2'b10
    } sarc_state_type;

endpackage

/* File: hdl/sarc_config_result.sv */
// Contract
// - Conversion clock divider field sits in config bits 7..3, value is ratio minus one.
// - Config bit 2 selects right (0) or left (1) justification.
// - Config bit 1 selects 10-bit (0) or 8-bit (1) conversions.
// - Eight-bit mode ignores the justification select.
// - Config bit 0 drives gain select: 0 half gain, 1 unity.
// - Right-justified high byte: zeros in 7..2, code top bits in 1..0.
// - Left-justified high byte holds code bits 9..2.
// - Eight-bit mode high byte holds the full 8-bit result.
// - Right-justified low byte holds code bits 7..0.
// - Left-justified low byte: code bits 1..0 in 7..6, zeros below.
// - Eight-bit mode conversion end writes zero to the low byte.
// - Converter stays shut down and converts nothing unless enable is one.
// - In-progress high during conversion; its fall at conversion end (not on disable) sets done flag with valid result.
// - Eight-bit conversions take two fewer conversion clocks.
// - Delayed tracking postpones conversion start by three conversion clocks.
`timescale 1ns/1ps

module sarc_config_result
    import sarc_pkg::*;
(
    // Clock and reset
    input  wire logic       clk,
    input  wire logic       nrst,
    // Special function register port
    input  wire logic [7:0] sfr_addr,
    input  wire logic       sfr_wr,
    input  wire logic [7:0] sfr_wdata,
    output logic      [7:0] sfr_rdata,
    // Control bits held elsewhere
    input  wire logic       converter_enable,
    input  wire logic       delayed_tracking_select,
    input  wire logic       start_conversion,
    input  wire logic       done_flag_clear,
    // Converter core
    input  wire logic [9:0] core_code,
    output logic            conversion_clock,
    output logic            core_powered,
    output logic            gain_select,
    output logic            eight_bit_mode_enable,
    output logic            conversion_in_progress,
    output logic            conversion_done_flag
);

    // ------------------------------------------------------------
    // Configuration register
    // ------------------------------------------------------------
    logic [7:0] config_r, config_nxt;
    logic [7:0] res_low_r, res_low_nxt;
    logic [7:0] res_hi_r, res_hi_nxt;

    logic [SARC_DIV_W-1:0] sar_clock_divider;
    logic                  left_justify_select;

    assign sar_clock_divider   = config_r[SARC_DIV_MSB:SARC_DIV_LSB];
    assign left_justify_select = config_r[SARC_LJST_BIT];
    assign eight_bit_mode_enable = config_r[SARC_8BIT_BIT];
    assign gain_select         = config_r[SARC_GAIN_BIT];
    assign core_powered        = converter_enable;

    // ------------------------------------------------------------
    // Conversion clock divider
    // ------------------------------------------------------------
    logic [4:0] div_cnt_r, div_cnt_nxt;
    logic       sar_tick;

    // one tick every divider plus one system clocks
    always_comb
    begin
        sar_tick    = (div_cnt_r >= sar_clock_divider);
        div_cnt_nxt = sar_tick ? SARC_DIV_ZERO : div_cnt_r + SARC_DIV_ONE;
        if (!converter_enable)
        begin
            div_cnt_nxt = SARC_DIV_ZERO;
        end
    end

    always_ff @(posedge clk)
    begin
        if (!nrst)
            div_cnt_r <= SARC_DIV_ZERO;
        else
            div_cnt_r <= div_cnt_nxt;
    end

    // Clock output as a registered pulse keeps it glitch free
    logic clk_out_r;
    always_ff @(posedge clk)
    begin
        if (!nrst)
            clk_out_r <= 1'b0;
        else
            clk_out_r <= sar_tick & converter_enable;
    end
    assign conversion_clock = clk_out_r;

    // ------------------------------------------------------------
    // Conversion sequencer
    // ------------------------------------------------------------
    sarc_state_type state_r, state_nxt;
    logic [3:0]     cnt_r, cnt_nxt;
    logic           done_r, done_nxt;
    logic           finish;

    always_comb
    begin
        state_nxt = state_r;
        cnt_nxt   = cnt_r;
        finish    = 1'b0;
        case (state_r)
            SARC_IDLE:
            begin
                if (start_conversion && converter_enable)
                begin
                    // delayed tracking adds three conversion clocks
                    if (delayed_tracking_select)
                    begin
                        state_nxt = SARC_DELAY;
                        cnt_nxt   = SARC_TRACK_DLY;
                    end
                    // eight-bit mode resolves two fewer bits
                    else
                    begin
                        state_nxt = SARC_CONV;
                        cnt_nxt   = eight_bit_mode_enable ? SARC_BITS_8 : SARC_BITS_10;
                    end
                end
            end
            SARC_DELAY:
            begin
                if (sar_tick)
                begin
                    cnt_nxt = cnt_r - SARC_CNT_ONE;
                    if (cnt_r == SARC_CNT_ONE)
                    begin
                        state_nxt = SARC_CONV;
                        cnt_nxt   = eight_bit_mode_enable ? SARC_BITS_8 : SARC_BITS_10;
                    end
                end
            end
            SARC_CONV:
            begin
                if (sar_tick)
                begin
                    cnt_nxt = cnt_r - SARC_CNT_ONE;
                    if (cnt_r == SARC_CNT_ONE)
                    begin
                        state_nxt = SARC_IDLE;
                        finish    = 1'b1;
                    end
                end
            end
            default:
            begin
                state_nxt = SARC_IDLE;
                cnt_nxt   = SARC_CNT_ZERO;
            end
        endcase
        if (!converter_enable)
        begin
            state_nxt = SARC_IDLE;
            cnt_nxt   = SARC_CNT_ZERO;
            finish    = 1'b0;
        end
        // completion sets done, set wins over clear
        done_nxt = finish ? 1'b1 : (done_flag_clear ? 1'b0 : done_r);
    end

    always_ff @(posedge clk)
    begin
        if (!nrst)
        begin
            state_r <= SARC_IDLE;
            cnt_r   <= SARC_CNT_ZERO;
            done_r  <= 1'b0;
        end
        else
        begin
            state_r <= state_nxt;
            cnt_r   <= cnt_nxt;
            done_r  <= done_nxt;
        end
    end

    assign conversion_in_progress = (state_r != SARC_IDLE);
    assign conversion_done_flag   = done_r;

    // ------------------------------------------------------------
    // Result formatting and register writes
    // ------------------------------------------------------------
    always_comb
    begin
        config_nxt  = config_r;
        res_low_nxt = res_low_r;
        res_hi_nxt  = res_hi_r;
        if (sfr_wr)
        begin
            if (sfr_addr == SARC_ADDR_CONFIG)
                config_nxt = sfr_wdata;
            else if (sfr_addr == SARC_ADDR_RES_LOW)
                res_low_nxt = sfr_wdata;
            else if (sfr_addr == SARC_ADDR_RES_HI)
                res_hi_nxt = sfr_wdata;
        end
        // Completion overrides a same-cycle software write to the result
        if (finish)
        begin
            if (eight_bit_mode_enable)
            begin
                // full 8-bit result in high byte
                res_hi_nxt  = core_code[9:2];
                res_low_nxt = SARC_BYTE_ZERO;
            end
            else if (left_justify_select)
            begin
                // high byte holds top eight bits
                res_hi_nxt  = core_code[9:2];
                // two low bits at the top of low byte
                res_low_nxt = {core_code[1:0], 6'b00_0000};
            end
            else
            begin
                res_hi_nxt  = {6'b00_0000, core_code[9:8]};
                res_low_nxt = core_code[7:0];
            end
        end
    end

    always_ff @(posedge clk)
    begin
        if (!nrst)
        begin
            config_r  <= SARC_CONFIG_RST;
            res_low_r <= SARC_BYTE_ZERO;
            res_hi_r  <= SARC_BYTE_ZERO;
        end
        else
        begin
            config_r  <= config_nxt;
            res_low_r <= res_low_nxt;
            res_hi_r  <= res_hi_nxt;
        end
    end

    // Read mux, unmapped addresses read zero
    always_comb
    begin
        if (sfr_addr == SARC_ADDR_CONFIG)
            sfr_rdata = config_r;
        else if (sfr_addr == SARC_ADDR_RES_LOW)
            sfr_rdata = res_low_r;
        else if (sfr_addr == SARC_ADDR_RES_HI)
            sfr_rdata = res_hi_r;
        else
            sfr_rdata = SARC_BYTE_ZERO;
    end

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    chk_done_on_end: assert property (@(posedge clk) disable iff (!nrst)
        (state_r == SARC_CONV && state_nxt == SARC_IDLE && converter_enable) |=> conversion_done_flag)
        else $error("done flag not set at conversion end");
    chk_idle_when_off: assert property (@(posedge clk) disable iff (!nrst)
        !converter_enable |=> !conversion_in_progress)
        else $error("busy while disabled");
    chk_eight_low_zero: assert property (@(posedge clk) disable iff (!nrst)
        (finish && eight_bit_mode_enable) |=> (res_low_r == SARC_BYTE_ZERO))
        else $error("low byte not zero in 8-bit mode");
    chk_right_hi_fmt: assert property (@(posedge clk) disable iff (!nrst)
        (finish && !eight_bit_mode_enable && !left_justify_select) |=> (res_hi_r[7:2] == 6'b00_0000))
        else $error("right-justified high byte not padded");
    chk_left_low_fmt: assert property (@(posedge clk) disable iff (!nrst)
        (finish && !eight_bit_mode_enable && left_justify_select) |=> (res_low_r[5:0] == 6'b00_0000))
        else $error("left-justified low byte not padded");
    chk_eight_hi_val: assert property (@(posedge clk) disable iff (!nrst)
        (finish && eight_bit_mode_enable) |=> (res_hi_r == $past(core_code[9:2])))
        else $error("8-bit high byte wrong");
    chk_tick_period: assert property (@(posedge clk) disable iff (!nrst)
        (sar_tick && converter_enable && sar_clock_divider == SARC_DIV_ONE && $stable(config_r) && !sfr_wr)
        |=> !sar_tick ##1 sar_tick)
        else $error("conversion clock period wrong");
    chk_tick_count: assert property (@(posedge clk) disable iff (!nrst)
        (converter_enable && !sar_tick) |=> (div_cnt_r == $past(div_cnt_r) + SARC_DIV_ONE))
        else $error("divider counter did not advance");
    chk_delay_entry: assert property (@(posedge clk) disable iff (!nrst)
        (state_r == SARC_IDLE && start_conversion && converter_enable && delayed_tracking_select)
        |=> (state_r == SARC_DELAY && cnt_r == SARC_TRACK_DLY))
        else $error("delayed tracking not entered");
    chk_conv_len: assert property (@(posedge clk) disable iff (!nrst)
        (state_r != SARC_CONV && state_nxt == SARC_CONV && converter_enable)
        |=> (cnt_r == ($past(eight_bit_mode_enable) ? SARC_BITS_8 : SARC_BITS_10)))
        else $error("conversion length wrong");

endmodule // sarc_config_result

/* File: verification/sarc_core_model.sv */
`timescale 1ns/1ps

// ------------------------------------------------------------
// Converter core stand-in
// ------------------------------------------------------------
module sarc_core_model
(
    // Converter handshake
    input  wire logic       busy,
    input  wire logic [9:0] code_value,
    output logic      [9:0] core_code
);
    // Code is only valid while converting; outside that the bits are inverted
    // so a sample taken at the wrong moment shows up as a wrong result
    assign core_code = busy ? code_value : ~code_value;
endmodule // sarc_core_model

/* File: verification/testbench.sv */
`timescale 1ns/1ps

module testbench
    import sarc_pkg::*;
;
    // ------------------------------------------------------------
    // Signals
    // ------------------------------------------------------------
    logic       clk;
    logic       nrst;
    logic [7:0] sfr_addr;
    logic       sfr_wr;
    logic [7:0] sfr_wdata;
    logic [7:0] sfr_rdata;
    logic       converter_enable;
    logic       delayed_tracking_select;
    logic       start_conversion;
    logic       done_flag_clear;
    logic [9:0] code_value;
    logic [9:0] core_code;
    logic       conversion_clock;
    logic       gain_select;
    logic       eight_bit_mode_enable;
    logic       conversion_in_progress;
    logic       conversion_done_flag;
    int         n_mismatch;
    int         comparisons;
    int         cycles;
    int         n10;
    int         n8;
    int         nd;
    int         per;
    logic       core_powered;

    // ------------------------------------------------------------
    // Design, core model and clock
    // ------------------------------------------------------------
    sarc_config_result uut (.clk(clk), .nrst(nrst), .sfr_addr(sfr_addr), .sfr_wr(sfr_wr),
        .sfr_wdata(sfr_wdata), .sfr_rdata(sfr_rdata), .converter_enable(converter_enable),
        .delayed_tracking_select(delayed_tracking_select), .start_conversion(start_conversion),
        .done_flag_clear(done_flag_clear), .core_code(core_code), .conversion_clock(conversion_clock),
        .core_powered(core_powered), .gain_select(gain_select), .eight_bit_mode_enable(eight_bit_mode_enable),
        .conversion_in_progress(conversion_in_progress), .conversion_done_flag(conversion_done_flag));

    sarc_core_model core (.busy(conversion_in_progress), .code_value(code_value), .core_code(core_code));

    // 40 MHz system clock
    always #12.5 clk = ~clk;

    // Hang guard: the whole run needs well under a thousand cycles
    always @(posedge clk)
    begin
        cycles <= cycles + 1;
        if (cycles == 5000)
        begin
            n_mismatch++;
            stop_test();
        end
    end

    // ------------------------------------------------------------
    // Tasks
    // ------------------------------------------------------------
    task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
        comparisons++;
        if (seen !== exp)
        begin
            n_mismatch++;
            $display("Error %s expected %h seen %h", what, exp, seen);
        end
    endtask

    // Register write: one-cycle strobe, returns mid-cycle so the new value has settled
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk);
        sfr_addr  <= a;
        sfr_wdata <= d;
        sfr_wr    <= 1'b1;
        @(posedge clk);
        sfr_wr    <= 1'b0;
        @(negedge clk);
    endtask

    // Read is combinational, so it is sampled mid-cycle
    task automatic rchk(input string what, input logic [7:0] a, input logic [7:0] exp);
        @(posedge clk);
        sfr_addr <= a;
        @(negedge clk);
        check(what, {8'h00, sfr_rdata}, {8'h00, exp});
    endtask

    // Spacing of the last two conversion clock pulses over twenty cycles
    task automatic sar_period(output int p);
        int t;
        t = -1;
        p = 0;
        for (int i = 0; i < 20; i++)
        begin
            @(negedge clk);
            if (conversion_clock === 1'b1)
            begin
                if (t >= 0)
                    p = i - t;
                t = i;
            end
        end
    endtask

    // Starts a conversion and counts busy cycles until it drops
    task automatic convert(input logic [9:0] code, output int n);
        n = 0;
        @(posedge clk);
        code_value       <= code;
        start_conversion <= 1'b1;
        @(posedge clk);
        start_conversion <= 1'b0;
        for (int i = 0; i < 300; i++)
        begin
            @(negedge clk);
            if (conversion_in_progress === 1'b1)
                n++;
            else if (n > 0)
                break;
        end
    endtask

    task automatic stop_test();
        $display("counts: %0d mismatches, %0d comparisons", n_mismatch, comparisons);
        if (n_mismatch == 0 && comparisons > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask

    // ------------------------------------------------------------
    // Test sequence
    // ------------------------------------------------------------
    initial
    begin
        clk = 0; nrst = 0; sfr_addr = 8'h00; sfr_wr = 0; sfr_wdata = 8'h00; converter_enable = 0;
        delayed_tracking_select = 0; start_conversion = 0; done_flag_clear = 0; code_value = 10'h000;
        n_mismatch = 0; comparisons = 0; cycles = 0;
        repeat (3) @(posedge clk);
        nrst <= 1'b1;
        rchk("config reset", SARC_ADDR_CONFIG, SARC_CONFIG_RST);
        rchk("low reset", SARC_ADDR_RES_LOW, 8'h00);
        rchk("high reset", SARC_ADDR_RES_HI, 8'h00);
        rchk("unmapped", 8'hbf, 8'h00);
        check("gain reset", {15'h0, gain_select}, 16'h0001);
        check("8bit reset", {15'h0, eight_bit_mode_enable}, 16'h0000);
        $display("test reset done");
        // Start while disabled must be ignored
        convert(10'h2a5, nd);
        check("busy disabled", 16'(nd), 16'h0000);
        check("sar clk disabled", {15'h0, conversion_clock}, 16'h0000);
        check("power off", {15'h0, core_powered}, 16'h0000);
        $display("test disabled done");
        @(posedge clk);
        converter_enable <= 1'b1;
        wr(SARC_ADDR_CONFIG, 8'h18);
        check("gain half", {15'h0, gain_select}, 16'h0000);
        check("power on", {15'h0, core_powered}, 16'h0001);
        sar_period(per);
        check("sar period", 16'(per), 16'h0004);
        wr(SARC_ADDR_CONFIG, 8'h08);
        sar_period(per);
        check("sar period one", 16'(per), 16'h0002);
        wr(SARC_ADDR_RES_LOW, 8'h3c);
        rchk("low write", SARC_ADDR_RES_LOW, 8'h3c);
        $display("test divider done");
        // Divider zero makes busy counts exact
        wr(SARC_ADDR_CONFIG, 8'h00);
        convert(10'h2a5, n10);
        check("done set", {15'h0, conversion_done_flag}, 16'h0001);
        rchk("high right", SARC_ADDR_RES_HI, 8'h02);
        rchk("low right", SARC_ADDR_RES_LOW, 8'ha5);
        @(posedge clk);
        done_flag_clear <= 1'b1;
        @(posedge clk);
        done_flag_clear <= 1'b0;
        @(negedge clk);
        check("done clear", {15'h0, conversion_done_flag}, 16'h0000);
        $display("test right justify done");
        wr(SARC_ADDR_CONFIG, 8'h04);
        convert(10'h2a5, nd);
        rchk("high left", SARC_ADDR_RES_HI, 8'ha9);
        rchk("low left", SARC_ADDR_RES_LOW, 8'h40);
        $display("test left justify done");
        // Eight-bit mode with justify still set
        wr(SARC_ADDR_CONFIG, 8'h06);
        check("8bit on", {15'h0, eight_bit_mode_enable}, 16'h0001);
        convert(10'h2a5, n8);
        rchk("high 8bit", SARC_ADDR_RES_HI, 8'ha9);
        rchk("low 8bit", SARC_ADDR_RES_LOW, 8'h00);
        check("8bit shorter", 16'(n10 - n8), 16'h0002);
        $display("test 8bit done");
        wr(SARC_ADDR_CONFIG, 8'h00);
        @(posedge clk);
        delayed_tracking_select <= 1'b1;
        convert(10'h15a, nd);
        check("delay longer", 16'(nd - n10), 16'h0003);
        rchk("low delayed", SARC_ADDR_RES_LOW, 8'h5a);
        $display("test delayed done");
        stop_test();
    end
endmodule // testbench
